// ---- bench/can_rx_acceptance_filter_tb_top.sv ----
// Self-checking bench for the receive acceptance filter
`timescale 1ns/100ps
`default_nettype none
module can_rx_acceptance_filter_tb_top;
  import carf_pkg::*;
  logic cyc, stb, we, ack, rx_valid, dma_req, dma_ack, hold_tx, tx_start, tx_done;
  logic mclk = 1'h0;
  logic nrst;
  logic [7:0]  adr, tx_pending, tx_remote, txen;
  logic [3:0]  sel, dma_buf;
  logic [31:0] wdat, rdat;
  logic [2:0]  dma_word, tx_start_sel, tx_done_sel;
  logic [15:0] dma_data, fen;
  carf_frame_t rx_frame, f;
  logic [15:0] fstd [16], fext [16], mstd [3], mext [3];
  logic [1:0]  msel [16];
  logic [3:0]  fbp [16];
  logic [22:0] dq [$];
  logic [31:0] rq [$];
  int failures, n_compared, k;
  always #4 mclk = ~mclk;
  carf_rx_filter u_dut (.MCLK(mclk), .NRST(nrst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .RX_VALID(rx_valid),
    .RX_FRAME(rx_frame), .DMA_REQ(dma_req), .DMA_ACK(dma_ack), .DMA_BUF(dma_buf),
    .DMA_WORD(dma_word), .DMA_DATA(dma_data), .TX_START(tx_start), .TX_START_SEL(tx_start_sel),
    .TX_DONE(tx_done), .TX_DONE_SEL(tx_done_sel), .TX_PENDING(tx_pending), .TX_REMOTE(tx_remote));
  carf_engine_model u_eng (.MCLK(mclk), .NRST(nrst), .DMA_REQ(dma_req), .DMA_ACK(dma_ack),
    .HOLD_TX(hold_tx), .TX_PENDING(tx_pending), .TX_START(tx_start),
    .TX_START_SEL(tx_start_sel), .TX_DONE(tx_done), .TX_DONE_SEL(tx_done_sel));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("compared=%0d mismatches=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // One classic cycle; the request holds until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge mclk);
    // Only the watchdog ends a wait for the answer
    while (ack !== 1'h1) begin
      @(posedge mclk);
    end
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge mclk);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(1'h0, a, 32'h0);
  endtask : rd
  function automatic int hit(input carf_frame_t g);
    logic [28:0] mk;
    for (int i = 0; i < NFILT; i++) begin
      if (fen[i] && msel[i] != MSK_RSVD) begin
        mk = {mstd[msel[i]][15:5], mstd[msel[i]][1:0], mext[msel[i]]};
        if (!g.ide) mk[17:0] = 18'h0;
        if ((({g.std_identifier, g.ext_identifier} ^ {fstd[i][15:5], fstd[i][1:0], fext[i]}) & mk) == 29'h0 &&
            !(mstd[msel[i]][F_TYPE] && fstd[i][F_TYPE] != g.ide)) return i;
      end
    end
    return -1;
  endfunction : hit
  // Notes the eight expected DMA words, then hands the frame over
  task automatic send(input carf_frame_t g, input logic live);
    logic [15:0] w [8];
    int h;
    h = hit(g);
    w = '{{3'h0, g.std_identifier, g.ide | g.rtr, g.ide}, {4'h0, g.ext_identifier[17:6]},
          {g.ext_identifier[5:0], g.rtr, 5'h00, g.dlc}, g.data[15:0], g.data[31:16], g.data[47:32],
          g.data[63:48], {12'h000, 4'(h)}};
    if (live && h >= 0 && !(fbp[h] < 4'h8 && txen[fbp[h][2:0]])) begin
      for (int i = 0; i < 8; i++) dq.push_back({fbp[h], 3'(i), w[i]});
    end
    rx_frame <= g;
    rx_valid <= 1'h1;
    @(posedge mclk);
    rx_valid <= 1'h0;
    rx_frame <= ~g;
    repeat (3) @(posedge mclk);
    while (dma_req !== 1'h0) @(posedge mclk);
  endtask : send
  task automatic cfg();
    logic [31:0] bp [4];
    logic [31:0] ms [2];
    bp = '{default: 32'h0};
    ms = '{default: 32'h0};
    for (int i = 0; i < 16; i++) begin
      bp[i / 4][4 * (i % 4) +: 4] = fbp[i];
      ms[i / 8][2 * (i % 8) +: 2] = msel[i];
    end
    wb(1'h1, A_FEN, {16'h0, fen});
    wb(1'h1, A_MSEL_LO, ms[0]);
    wb(1'h1, A_MSEL_HI, ms[1]);
    for (int i = 0; i < 4; i++) wb(1'h1, A_BPTR + 8'(4 * i), bp[i]);
    for (int i = 0; i < 3; i++) wb(1'h1, A_MASK + 8'(8 * i), {16'h0, mstd[i]});
    for (int i = 0; i < 3; i++) wb(1'h1, A_MASK + 8'(8 * i + 4), {16'h0, mext[i]});
    for (int i = 0; i < 16; i++) wb(1'h1, A_FILT + 8'(8 * i), {16'h0, fstd[i]});
    for (int i = 0; i < 16; i++) wb(1'h1, A_FILT + 8'(8 * i + 4), {16'h0, fext[i]});
    rd(A_FEN, {16'h0, fen});
    rd(A_MSEL_HI, ms[1]);
    rd(A_FILT + 8'h78, {16'h0, fstd[15]});
  endtask : cfg
  always @(posedge mclk) begin
    if (dma_req === 1'h1 && dma_ack === 1'h1) begin
      if (dq.size() == 0) chk({9'h0, dma_buf, dma_word, dma_data}, 32'hFFFFFFFF);
      else chk({9'h0, dma_buf, dma_word, dma_data}, {9'h0, dq.pop_front()});
    end
    if (ack === 1'h1 && we === 1'h0 && rq.size() > 0) chk(rdat, rq.pop_front());
  end
  initial begin
    #400000;
    failures++;
    report_and_stop();
  end
  initial begin
    {cyc, stb, we, rx_valid, hold_tx, nrst} = 6'h0;
    {adr, sel, wdat, rx_frame, txen} = '0;
    sel = 4'hF;
    void'($urandom(32'h03f914cb));
    repeat (10) @(posedge mclk);
    nrst <= 1'h1;
    @(posedge mclk);
    rd(A_CTRL, {24'h0, MODE_CONFIG, 2'h0, RST_REQUESTED_MODE});
    rd(A_FEN, {16'h0, RST_FEN});
    rd(8'h3C, 32'h0);
    $display("test reset done");
    fen = 16'($urandom);
    for (int i = 0; i < 16; i++) begin
      {fstd[i], fext[i], msel[i], fbp[i]} = {$urandom, 2'($urandom), 4'($urandom)};
      if (i < 3) {mstd[i], mext[i]} = $urandom & $urandom & $urandom;
    end
    cfg();
    for (int i = 0; i < 4; i++) send(carf_frame_t'({$urandom, $urandom, $urandom, 3'h0}), 1'h0);
    wb(1'h1, A_CTRL, {29'h0, MODE_NORMAL});
    rd(A_CTRL, 32'h0);
    for (int i = 0; i < 60; i++) begin
      f = carf_frame_t'({$urandom, $urandom, $urandom, 3'h0});
      k = $urandom_range(15);
      f.ide = fstd[k][F_TYPE] ^ ($urandom_range(5) == 0);
      f.std_identifier = fstd[k][15:5] ^ 11'($urandom & $urandom & $urandom);
      f.ext_identifier = f.ide ? {fstd[k][1:0], fext[k]} ^ 18'($urandom & $urandom & $urandom) : 18'h0;
      send(f, 1'h1);
    end
    $display("test filtering done");
    wb(1'h1, A_CTRL, {29'h0, MODE_CONFIG});
    {fen, msel[0], fbp[0], mstd[0], txen} = {16'h0001, 2'h0, 4'h2, 16'hFFE0, 8'h04};
    fstd[0] = 16'hA5A0;
    hold_tx <= 1'h1;
    wb(1'h1, A_TXCTL, 32'h00000404);
    cfg();
    wb(1'h1, A_CTRL, {29'h0, MODE_NORMAL});
    f = '0;
    {f.rtr, f.std_identifier, f.dlc} = {1'h1, fstd[0][15:5], 4'h3};
    send(f, 1'h1);
    chk(tx_pending, 8'h04);
    rd(A_TXCTL, 32'h00040404);
    wb(1'h1, A_TXCTL, 32'h00000404);
    chk(tx_pending, 8'h00);
    wb(1'h1, A_TXCTL, 32'h01240404);
    chk({tx_remote, tx_pending}, 16'h0104);
    wb(1'h1, A_CTRL, 32'h00001000);
    chk(tx_pending, 8'h00);
    wb(1'h1, A_TXCTL, 32'h00040404);
    hold_tx <= 1'h0;
    while (tx_start !== 1'h1) @(posedge mclk);
    wb(1'h1, A_TXCTL, 32'h00000404);
    chk(tx_pending, 8'h04);
    while (tx_pending !== 8'h00) @(posedge mclk);
    rd(A_TXCTL, 32'h00000404);
    rd(A_STAT, 32'h00000120);
    // A second frame while the first is judged is dropped and flagged
    rx_frame <= f;
    rx_valid <= 1'h1;
    repeat (2) @(posedge mclk);
    rx_valid <= 1'h0;
    repeat (2) @(posedge mclk);
    rd(A_STAT, 32'h00000320);
    wb(1'h1, A_STAT, 32'h00000200);
    rd(A_STAT, 32'h00000120);
    $display("test remote reply done");
    chk(32'(dq.size()), 32'h0);
    report_and_stop();
  end
endmodule : can_rx_acceptance_filter_tb_top
`default_nettype wire

// ---- bench/carf_engine_model.sv ----
// Behavioural protocol engine and receive DMA channel facing the filter
`timescale 1ns/100ps
`default_nettype none
module carf_engine_model
  import carf_pkg::*;
(
  // Clock and reset
  input  wire logic       MCLK,
  input  wire logic       NRST,
  // DMA channel and test control
  input  wire logic       DMA_REQ,
  output logic            DMA_ACK,
  input  wire logic       HOLD_TX,
  // Transmit handshake
  input  wire logic [7:0] TX_PENDING,
  output logic            TX_START,
  output logic      [2:0] TX_START_SEL,
  output logic            TX_DONE,
  output logic      [2:0] TX_DONE_SEL
);
  logic       busy;
  logic [3:0] cnt;
  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      DMA_ACK      <= 1'h0;
      TX_START     <= 1'h0;
      TX_START_SEL <= 3'h0;
      TX_DONE      <= 1'h0;
      TX_DONE_SEL  <= 3'h0;
      busy         <= 1'h0;
      cnt          <= 4'h0;
    end else begin
      // Random stalls; never two acks in a row so the last word is not acked twice
      DMA_ACK     <= DMA_REQ && !DMA_ACK && ($urandom_range(1) == 1);
      TX_START    <= 1'h0;
      TX_DONE     <= 1'h0;
      TX_DONE_SEL <= 3'($urandom);
      if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        TX_DONE     <= 1'h1;
        TX_DONE_SEL <= TX_START_SEL;
        busy        <= 1'h0;
        cnt         <= 4'h2;
      end else if (!HOLD_TX && TX_PENDING != 8'h00) begin
        TX_START <= 1'h1;
        busy     <= 1'h1;
        cnt      <= 4'h8;
        for (int i = 7; i >= 0; i--) begin
          if (TX_PENDING[i]) TX_START_SEL <= 3'(i);
        end
      end
    end
  end
endmodule : carf_engine_model
`default_nettype wire

// ---- core/carf_pkg.sv ----
// Constants, types and register map of the CAN receive acceptance filter
package carf_pkg;
  localparam int NFILT = 16;
  localparam int NMASK = 3;
  localparam int NTX   = 8;
  localparam int MSG_WORDS = 8;
  // Register byte offsets
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_FEN     = 8'h04;
  localparam logic [7:0] A_MSEL_LO = 8'h08;
  localparam logic [7:0] A_MSEL_HI = 8'h0C;
  localparam logic [7:0] A_BPTR    = 8'h10;
  localparam logic [7:0] A_TXCTL   = 8'h20;
  localparam logic [7:0] A_STAT    = 8'h24;
  localparam logic [7:0] A_MASK    = 8'h40;
  localparam logic [7:0] A_FILT    = 8'h80;
  // Field positions
  localparam int F_REQUESTED_MODE  = 0;
  localparam int F_CURRENT_MODE_STATUS = 5;
  localparam int F_ABORT  = 12;
  localparam int F_TYPE   = 3;
  localparam int F_SID    = 5;
  localparam int F_TXEN   = 0;
  localparam int F_AUTO_REMOTE_REPLY_EN  = 8;
  localparam int F_SEND_REQUEST  = 16;
  localparam int F_TXRTR  = 24;
  localparam int F_HIT    = 0;
  localparam int F_DEST   = 4;
  localparam int F_FOUND  = 8;
  localparam int F_OVR    = 9;
  // Modes, codes and reset values
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_CONFIG = 3'h4;
  localparam logic [1:0] MSK_RSVD    = 2'h3;
  localparam logic [3:0] BP_FIFO     = 4'hF;
  localparam logic [2:0] LAST_WORD   = 3'h7;
  localparam logic [2:0] RST_REQUESTED_MODE   = MODE_CONFIG;
  localparam logic [15:0] RST_FEN    = 16'h0000;

  typedef enum logic [1:0] {S_IDLE = 2'b00, S_MATCH = 2'b01, S_XFER = 2'b11} carf_st_t;

  typedef struct packed {
    logic        ide;
    logic        rtr;
    logic [10:0] std_identifier;
    logic [17:0] ext_identifier;
    logic [3:0]  dlc;
    logic [63:0] data;
  } carf_frame_t;

  typedef struct packed {
    carf_st_t               st;
    logic                   ack;
    logic [31:0]            rdat;
    logic [2:0]             requested_mode;
    logic [2:0]             current_mode_status;
    logic [15:0]            fen;
    logic [15:0][1:0]       msel;
    logic [15:0][3:0]       fbp;
    logic [NTX-1:0]         txen;
    logic [NTX-1:0]         auto_remote_reply_en;
    logic [NTX-1:0]         send_request;
    logic [NTX-1:0]         txrtr;
    logic [NTX-1:0]         busy;
    logic [NMASK-1:0][15:0] mstd;
    logic [NMASK-1:0][15:0] mext;
    logic [15:0][15:0]      fstd;
    logic [15:0][15:0]      fext;
    carf_frame_t            asmb;
    logic [3:0]             hit;
    logic [3:0]             dest;
    logic                   found;
    logic                   ovr;
    logic [2:0]             widx;
    logic [15:0]            dword;
  } carf_state_t;
endpackage : carf_pkg

// ---- core/carf_rx_filter.sv ----
// CAN receive acceptance filter, remote reply and transmit request control
// Summary of operation
// - Each frame received while idle and outside configuration mode is held in an assembly buffer, then checked by 16 filters.
// - Standard frames compare 11 STD_IDENTIFIER bits; extended compare STD_IDENTIFIER plus 18 EXT_IDENTIFIER bits.
// - A full match on an enabled filter raises a DMA request to store it, unless its pointer names an enabled transmit buffer.
// - A stored message is eight words, status word included, in transmit layout.
// - Enable register bit n enables filter n; disabled filters never match.
// - Each filter holds a standard and an extended identifier register.
// - Mask select 00, 01, 10 pick masks 0, 1, 2; 11 is reserved.
// - One select register covers filters 7..0, the other filters 15..8.
// - An identifier bit with mask bit zero always matches.
// - An identifier bit with mask bit one matches only if message equals filter.
// - Filter standard register bit 3 wants standard (0) or extended (1) frames.
// - Mask standard register bit 3 decides whether the frame type bit applies.
// - A matching remote frame sets the send request of an auto-reply buffer.
// - A buffer marked remote is sent as a remote frame with no data.
// - Send request stays set until the frame has been completely sent, then clears.
// - Mode 4 is configuration, 0 normal; the entered mode is reported apart.
// - The matching filter's pointer names the buffer; 1111 means the receive FIFO.
// - Only buffers 0 to 7 transmit and reply; 8 to 14 only receive.
// - An automatic reply uses its own length code, not the request's.
// - Clearing a request or abort-all cancels only frames not yet started.
`timescale 1ns/100ps
`default_nettype none
module carf_rx_filter
  import carf_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        NRST,
  // Wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // Received frames from the protocol engine
  input  wire logic        RX_VALID,
  input  wire carf_frame_t RX_FRAME,
  // DMA transfer of accepted messages
  output logic             DMA_REQ,
  input  wire logic        DMA_ACK,
  output logic      [3:0]  DMA_BUF,
  output logic      [2:0]  DMA_WORD,
  output logic      [15:0] DMA_DATA,
  // Transmit buffer handshake with the protocol engine
  input  wire logic        TX_START,
  input  wire logic [2:0]  TX_START_SEL,
  input  wire logic        TX_DONE,
  input  wire logic [2:0]  TX_DONE_SEL,
  output logic      [7:0]  TX_PENDING,
  output logic      [7:0]  TX_REMOTE
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return r;
  endfunction : bmerge

  function automatic logic filt_hit(input carf_frame_t f, input logic [15:0] fs,
                                    input logic [15:0] fe, input logic [15:0] ms,
                                    input logic [15:0] me);
    logic [28:0] fid;
    logic [28:0] mid;
    logic [28:0] mm;
    logic        ok;
    fid = {fs[15:F_SID], fs[1:0], fe};
    mm  = {ms[15:F_SID], ms[1:0], me};
    mid = {f.std_identifier, f.ext_identifier};
    if (!f.ide) begin
      mm[17:0] = 18'h00000;
    end
    ok = ((fid ^ mid) & mm) == 29'h0;
    if (ms[F_TYPE] && (fs[F_TYPE] != f.ide)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : filt_hit

  // Storage layout is the transmit buffer layout, last word holds status
  function automatic logic [15:0] msg_word(input carf_frame_t f, input logic [2:0] w,
                                           input logic [3:0] hit);
    logic [15:0] r;
    r = 16'h0000;
    case (w)
      3'h0:    r = {3'h0, f.std_identifier, (f.ide | f.rtr), f.ide};
      3'h1:    r = {4'h0, f.ext_identifier[17:6]};
      3'h2:    r = {f.ext_identifier[5:0], f.rtr, 5'h00, f.dlc};
      3'h7:    r = {12'h000, hit};
      default: r = f.data[(32'(w) - 32'd3) * 16 +: 16];
    endcase
    return r;
  endfunction : msg_word

  ////////////////////////////////////////////////////////////////////////////
  // State

  carf_state_t s;
  carf_state_t next_s;
  logic [31:0] rd;
  logic [31:0] wv;
  logic        wr;
  logic        found;
  logic [3:0]  hit;
  logic [3:0]  dst;
  logic [7:0]  fire;
  logic [7:0]  donev;
  logic [1:0]  sel;

  always_comb begin
    next_s = s;
    rd     = 32'h0;
    found  = 1'b0;
    hit    = 4'h0;
    fire   = 8'h00;
    donev  = 8'h00;
    sel    = 2'h0;
    wr     = CYC_I & STB_I & WE_I & s.ack;
    // Classic cycle: one wait state, ack drops the cycle after it rose
    next_s.ack = CYC_I & STB_I & ~s.ack;
    case (ADR_I)
      A_CTRL: begin
        rd[F_REQUESTED_MODE +: 3]  = s.requested_mode;
        rd[F_CURRENT_MODE_STATUS +: 3] = s.current_mode_status;
      end
      A_FEN:     rd[15:0] = s.fen;
      A_MSEL_LO: rd[15:0] = s.msel[7:0];
      A_MSEL_HI: rd[15:0] = s.msel[15:8];
      A_TXCTL:   rd = {s.txrtr, s.send_request, s.auto_remote_reply_en, s.txen};
      A_STAT: begin
        rd[F_HIT +: 4]  = s.hit;
        rd[F_DEST +: 4] = s.dest;
        rd[F_FOUND]     = s.found;
        rd[F_OVR]       = s.ovr;
      end
      default: begin
        if (ADR_I[7:4] == A_BPTR[7:4]) begin
          // Four pointer registers, four filters each
          rd[15:0] = s.fbp[32'(ADR_I[3:2]) * 4 +: 4];
        end else if (ADR_I[7] == A_FILT[7]) begin
          rd[15:0] = ADR_I[2] ? s.fext[ADR_I[6:3]] : s.fstd[ADR_I[6:3]];
        end else if (ADR_I[7:6] == A_MASK[7:6] && ADR_I[4:3] != MSK_RSVD && !ADR_I[5]) begin
          rd[15:0] = ADR_I[2] ? s.mext[ADR_I[4:3]] : s.mstd[ADR_I[4:3]];
        end
      end
    endcase
    if (CYC_I && STB_I && !s.ack) begin
      next_s.rdat = rd;
    end
    wv = bmerge(rd, DAT_I, SEL_I);

    // Register writes take effect on the acknowledged edge
    if (wr) begin
      case (ADR_I)
        A_CTRL: begin
          next_s.requested_mode = wv[F_REQUESTED_MODE +: 3];
          if (wv[F_ABORT]) begin
            next_s.send_request = s.send_request & s.busy;
          end
        end
        A_FEN:     next_s.fen = wv[15:0];
        A_MSEL_LO: next_s.msel[7:0] = wv[15:0];
        A_MSEL_HI: next_s.msel[15:8] = wv[15:0];
        A_TXCTL: begin
          next_s.txen  = wv[F_TXEN +: NTX];
          next_s.auto_remote_reply_en = wv[F_AUTO_REMOTE_REPLY_EN +: NTX];
          next_s.txrtr = wv[F_TXRTR +: NTX];
          // A started frame keeps its request until it completes
          next_s.send_request = wv[F_SEND_REQUEST +: NTX] | (s.send_request & s.busy);
        end
        default: begin
          if (ADR_I[7:4] == A_BPTR[7:4]) begin
            next_s.fbp[32'(ADR_I[3:2]) * 4 +: 4] = wv[15:0];
          end else if (ADR_I[7] == A_FILT[7]) begin
            if (ADR_I[2]) begin
              next_s.fext[ADR_I[6:3]] = wv[15:0];
            end else begin
              next_s.fstd[ADR_I[6:3]] = wv[15:0];
            end
          end else if (ADR_I[7:6] == A_MASK[7:6] && ADR_I[4:3] != MSK_RSVD && !ADR_I[5]) begin
            if (ADR_I[2]) begin
              next_s.mext[ADR_I[4:3]] = wv[15:0];
            end else begin
              next_s.mstd[ADR_I[4:3]] = wv[15:0];
            end
          end
        end
      endcase
    end

    // Transmit progress from the protocol engine
    if (TX_START) begin
      next_s.busy[TX_START_SEL] = 1'b1;
    end
    if (TX_DONE) begin
      donev[TX_DONE_SEL]         = 1'b1;
      next_s.busy[TX_DONE_SEL]   = 1'b0;
      next_s.send_request[TX_DONE_SEL]  = 1'b0;
    end
    // Mode changes wait until no frame is on the wire
    if (s.busy == 8'h00) begin
      next_s.current_mode_status = s.requested_mode;
    end

    // Filter evaluation, descending so the lowest index wins
    for (int i = NFILT - 1; i >= 0; i--) begin
      sel = s.msel[i];
      if (s.fen[i] && sel != MSK_RSVD &&
          filt_hit(s.asmb, s.fstd[i], s.fext[i], s.mstd[sel], s.mext[sel])) begin
        found = 1'b1;
        hit   = 4'(i);
      end
    end
    dst = s.fbp[hit];

    case (s.st)
      S_IDLE: begin
        if (RX_VALID && s.current_mode_status != MODE_CONFIG) begin
          next_s.asmb = RX_FRAME;
          next_s.st   = S_MATCH;
        end
      end
      S_MATCH: begin
        next_s.found = found;
        next_s.st    = S_IDLE;
        if (found) begin
          next_s.hit  = hit;
          next_s.dest = dst;
          if (dst != BP_FIFO && dst < 4'(NTX) && s.txen[dst[2:0]]) begin
            // A transmit buffer takes nothing; only a remote frame may trigger it
            if (s.asmb.rtr && s.auto_remote_reply_en[dst[2:0]]) begin
              fire[dst[2:0]] = 1'b1;
            end
          end else begin
            next_s.st    = S_XFER;
            next_s.widx  = 3'h0;
            next_s.dword = msg_word(s.asmb, 3'h0, hit);
          end
        end
      end
      S_XFER: begin
        if (DMA_ACK) begin
          if (s.widx == LAST_WORD) begin
            next_s.st = S_IDLE;
          end else begin
            next_s.widx  = s.widx + 3'h1;
            next_s.dword = msg_word(s.asmb, s.widx + 3'h1, s.hit);
          end
        end
      end
      default: next_s.st = S_IDLE;
    endcase
    // Frames arriving while one is still in hand are dropped and flagged
    if (RX_VALID && s.st != S_IDLE) begin
      next_s.ovr = 1'b1;
    end else if (wr && ADR_I == A_STAT && DAT_I[F_OVR] && SEL_I[1]) begin
      // Only a written one clears; the merged read value must not clear it
      next_s.ovr = 1'b0;
    end
    // Hardware set wins over software clear and completion
    next_s.send_request = next_s.send_request | fire;
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      s        <= '0;
      s.st     <= S_IDLE;
      s.requested_mode  <= RST_REQUESTED_MODE;
      s.current_mode_status <= RST_REQUESTED_MODE;
      s.fen    <= RST_FEN;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign DAT_O      = s.rdat;
  assign ACK_O      = s.ack;
  assign DMA_REQ    = s.st == S_XFER;
  assign DMA_BUF    = s.dest;
  assign DMA_WORD   = s.widx;
  assign DMA_DATA   = s.dword;
  assign TX_PENDING = s.send_request & s.txen;
  assign TX_REMOTE  = s.txrtr;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);

  sequence s_capture;
    RX_VALID && s.st == S_IDLE && s.current_mode_status != MODE_CONFIG;
  endsequence

  sequence s_judged;
    s.st == S_MATCH ##1 s.st != S_MATCH;
  endsequence

  a_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack held for more than one cycle");
  a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("bus request not answered in one cycle");
  a_frame_judged: assert property (s_capture |=> s_judged)
    else $error("captured frame not judged in one cycle");
  a_no_enable: assert property (s.st == S_MATCH && found |=> s.fen[s.hit])
    else $error("match came from a disabled filter");
  a_eight_words: assert property (DMA_REQ && DMA_ACK && DMA_WORD == LAST_WORD |=> !DMA_REQ)
    else $error("transfer did not end after eighth word");
  a_word_step: assert property (DMA_REQ && DMA_ACK && DMA_WORD != LAST_WORD
                                |=> DMA_REQ && DMA_WORD == $past(DMA_WORD) + 3'h1)
    else $error("word index did not advance");
  a_auto_reply: assert property (fire != 8'h00 |=> (s.send_request & $past(fire)) == $past(fire))
    else $error("remote frame did not raise send request");
  a_done_clear: assert property (TX_DONE && fire == 8'h00 |=> !s.send_request[$past(TX_DONE_SEL)])
    else $error("send request not cleared on completion");
  a_busy_kept: assert property (1'b1 |=> ($past(s.send_request & s.busy & ~donev) & ~s.send_request) == 8'h00)
    else $error("started frame was cancelled");
  a_mode_follow: assert property (s.busy == 8'h00 |=> s.current_mode_status == $past(s.requested_mode))
    else $error("mode status did not follow request");

endmodule : carf_rx_filter
`default_nettype wire
